// file: common/pixel_mapper_pkg.sv
// Purpose: shared constants for the double-pumped pixel mapper
// Assumes: 12-bit half-pixels, 7-bit lane words, eight data lanes
// Notes:   blanking patterns are written MSB first as sent
package pixel_mapper_pkg;
    localparam int HALF_W    = 12;
    localparam int PIX_W     = 24;
    localparam int IN_W      = 24;
    localparam int WORD_W    = 7;
    localparam int DATA6_W   = 6;
    localparam int LANES     = 8;
    localparam int PORT_LANES = 4;
    localparam int RD_W      = 6;
    localparam int SYNC_W    = 33;
    // Half-pixel field positions inside a 12-bit half
    localparam int LO_B_LSB  = 0;
    localparam int LO_B_MSB  = 7;
    localparam int LO_G_LSB  = 8;
    localparam int LO_G_MSB  = 11;
    localparam int HI_G_LSB  = 0;
    localparam int HI_G_MSB  = 3;
    localparam int HI_R_LSB  = 4;
    localparam int HI_R_MSB  = 11;
    // Second port sits on the upper twelve inputs
    localparam int PORT2_LSB = 12;
    localparam int PORT2_MSB = 23;
    // Assembled pixel: {R, G, B}
    localparam int PX_R_LSB  = 16;
    localparam int PX_R_MSB  = 23;
    // Idle clock-lane word and blanking patterns
    localparam logic [WORD_W-1:0] CLK_LANE_WORD = 7'h63;
    localparam logic [WORD_W-1:0] DE_HI_A  = 7'h78;
    localparam logic [WORD_W-1:0] DE_HI_B  = 7'h70;
    localparam logic [WORD_W-1:0] DE_LO_A  = 7'h7c;
    localparam logic [WORD_W-1:0] DE_LO_B  = 7'h60;
    localparam logic [WORD_W-1:0] SYN_HI_A = 7'h60;
    localparam logic [WORD_W-1:0] SYN_HI_B = 7'h7c;
    localparam logic [WORD_W-1:0] SYN_LO_A = 7'h70;
    localparam logic [WORD_W-1:0] SYN_LO_B = 7'h78;
    localparam logic [WORD_W-1:0] WORD_ZERO = 7'h00;
    localparam logic [3:0] DATA6_HALF = 4'h3;
    localparam logic signed [RD_W-1:0] RD_ZERO  = 6'sh00;
    localparam logic signed [RD_W-1:0] WORD_BITS = 6'sh07;
    localparam logic signed [RD_W-1:0] RD_BOUND = 6'sh0a;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
endpackage : pixel_mapper_pkg

// file: hw/lane_balancer.sv
// Purpose: one link lane word builder with running disparity
// Assumes: strobe_i is one ref_clk cycle per pixel
// Notes:   raw words do not touch the running disparity
`timescale 1ns/10ps
module lane_balancer
    import pixel_mapper_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    // Control
    input  wire logic              strobe_i,
    input  wire logic              enable_i,
    input  wire logic              force_raw_i,
    input  wire logic              balanced_i,
    input  wire logic              blank_i,
    // Data
    input  wire logic [WORD_W-1:0] raw_i,
    input  wire logic [WORD_W-1:0] pat_a_i,
    input  wire logic [WORD_W-1:0] pat_b_i,
    input  wire logic [DATA6_W-1:0] data_i,
    // Lane word
    output logic      [WORD_W-1:0] word_o
);
    function automatic logic [3:0] ones7(input logic [WORD_W-1:0] w);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < WORD_W; k++) begin
            n = n + {3'h0, w[k]};
        end
        return n;
    endfunction : ones7

    function automatic logic signed [RD_W-1:0] disp7(
        input logic [WORD_W-1:0] w);
        return $signed({1'b0, ones7(w), 1'b0}) - WORD_BITS;
    endfunction : disp7

    function automatic logic [RD_W-1:0] mag(
        input logic signed [RD_W-1:0] v);
        return (v < RD_ZERO) ? -v : v;
    endfunction : mag

    logic signed [RD_W-1:0] rd_r;
    logic signed [RD_W-1:0] rd_nxt;
    logic        [WORD_W-1:0] word_nxt;

    wire logic [3:0] data_ones = ones7({1'b0, data_i});
    // Invert when the data would push disparity further out
    // Ties invert when negative, else disparity creeps downward
    wire logic inv = ((rd_r > RD_ZERO) && (data_ones > DATA6_HALF)) ||
                     ((rd_r < RD_ZERO) && (data_ones <= DATA6_HALF));
    wire logic [WORD_W-1:0] coded_word = {inv, data_i ^ {DATA6_W{inv}}};
    wire logic pick_a = mag(rd_r + disp7(pat_a_i)) <=
                        mag(rd_r + disp7(pat_b_i));
    wire logic [WORD_W-1:0] pat_word = pick_a ? pat_a_i : pat_b_i;
    wire logic use_raw = force_raw_i || !balanced_i;
    wire logic tracks  = enable_i && balanced_i && !force_raw_i;

    always_comb begin
        word_nxt = word_o;
        rd_nxt   = rd_r;
        if (strobe_i) begin
            if (!enable_i) begin
                word_nxt = WORD_ZERO;
            end else if (use_raw) begin
                word_nxt = raw_i;
            end else if (blank_i) begin
                word_nxt = pat_word;
            end else begin
                word_nxt = coded_word;
            end
            if (!balanced_i) begin
                rd_nxt = RD_ZERO;
            end else if (tracks) begin
                rd_nxt = rd_r + disp7(word_nxt);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word_o <= WORD_ZERO;
            rd_r   <= RD_ZERO;
        end else begin
            word_o <= word_nxt;
            rd_r   <= rd_nxt;
        end
    end

    property p_raw_word;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        strobe_i && enable_i && use_raw |=> word_o == $past(raw_i);
    endproperty
    a_raw_word: assert property (p_raw_word)
        else $error("raw lane word not passed through");

    property p_bal_data;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        strobe_i && tracks && !blank_i |=>
            word_o[DATA6_W-1:0] ==
            ($past(data_i) ^ {DATA6_W{word_o[WORD_W-1]}});
    endproperty
    a_bal_data: assert property (p_bal_data)
        else $error("balanced data word malformed");

    property p_blank_pat;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        strobe_i && tracks && blank_i |=>
            (word_o == $past(pat_a_i)) || (word_o == $past(pat_b_i));
    endproperty
    a_blank_pat: assert property (p_blank_pat)
        else $error("blanking word is not a control pattern");

    property p_rd_bound;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        mag(rd_r) <= RD_BOUND;
    endproperty
    a_rd_bound: assert property (p_rd_bound)
        else $error("running disparity out of bound");
endmodule : lane_balancer

// file: hw/pixel_mapper.sv
// Purpose: double-pumped pixel input mapping onto link lane words
// Assumes: all pins asynchronous to ref_clk_i, pixel clock far slower
// Notes:   lane words are parallel, serializing happens downstream
// Functional notes
// - Two-pixel mode takes a second pixel from inputs 12-23 on lanes 4-7.
// - The first edge captures the low half, the second the high half.
// - Clock style 0 samples at crossings of the differential clock pair.
// - Low half carries green 3..0 on inputs 11..8 and blue on 7..0.
// - High half carries red on inputs 11..4 and green 7..4 on 3..0.
// - Without balance coding lanes carry raw data, port one on 0-3.
// - With balance coding active pixels are sent DC balanced.
// - Balanced blanking sends the display-active pattern on the primary clock lane only.
// - Balanced blanking sends hsync on lane 0 and vsync on lane 1.
// - Low enable polarity swaps the display-active patterns and takes display-active as active low.
// - High enable polarity takes display-active as active high.
// - Single-pixel mode uses only lanes 0-3 for the pixel stream.
// - Single-pixel mode disables lanes 4-7 and the second clock lane.
`timescale 1ns/10ps
module pixel_mapper
    import pixel_mapper_pkg::*;
(
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    arst_n_i,
    // Host pixel input
    input  wire logic                    pixel_clk_p_i,
    input  wire logic                    pixel_clk_n_i,
    input  wire logic [IN_W-1:0]         pixel_input_bits_i,
    input  wire logic                    display_active_i,
    input  wire logic                    hsync_i,
    input  wire logic                    vsync_i,
    // Straps
    input  wire logic                    two_pixel_mode_i,
    input  wire logic                    disparity_coding_enable_i,
    input  wire logic                    clock_input_style_select_i,
    input  wire logic                    data_enable_polarity_i,
    // Link lane words
    output logic [LANES*WORD_W-1:0]      link_lanes_o,
    output logic [WORD_W-1:0]            primary_link_clock_lane_o,
    output logic [WORD_W-1:0]            second_link_clock_lane_o,
    output logic [LANES-1:0]             lane_enable_o,
    output logic                         second_clock_enable_o,
    output logic                         word_valid_o
);
    localparam int UNITS = LANES + 2;
    localparam int PRI_CLK = LANES;
    localparam int SEC_CLK = LANES + 1;

    // Whole bundle double-synchronised; data is stable half a period
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    wire logic [SYNC_W-1:0] sync_in = {pixel_clk_p_i, pixel_clk_n_i,
        pixel_input_bits_i, display_active_i, hsync_i, vsync_i,
        two_pixel_mode_i, disparity_coding_enable_i,
        clock_input_style_select_i, data_enable_polarity_i};

    wire logic            p_s;
    wire logic            n_s;
    wire logic [IN_W-1:0] d_s;
    wire logic            de_s;
    wire logic            hs_s;
    wire logic            vs_s;
    wire logic            two_s;
    wire logic            code_s;
    wire logic            style_s;
    wire logic            pol_s;
    assign {p_s, n_s, d_s, de_s, hs_s, vs_s, two_s, code_s, style_s,
            pol_s} = sync2_r;

    logic                 clk_lvl_r;
    logic                 clk_lvl_nxt;
    logic                 have_low_r;
    logic [HALF_W-1:0]    low1_r;
    logic [HALF_W-1:0]    low2_r;
    logic [PIX_W-1:0]     pix1_r;
    logic [PIX_W-1:0]     pix2_r;
    logic                 de_r;
    logic                 hs_r;
    logic                 vs_r;
    logic                 stb_r;

    assign clk_lvl_nxt = style_s ? p_s : ((p_s != n_s) ? p_s : clk_lvl_r);
    wire logic first_edge  = clk_lvl_nxt && !clk_lvl_r;
    wire logic second_edge = !clk_lvl_nxt && clk_lvl_r && have_low_r;

    wire logic [HALF_W-1:0] hi1 = d_s[HALF_W-1:0];
    wire logic [HALF_W-1:0] hi2 = d_s[PORT2_MSB:PORT2_LSB];
    wire logic [PIX_W-1:0] pix1_nxt = {hi1[HI_R_MSB:HI_R_LSB],
        hi1[HI_G_MSB:HI_G_LSB], low1_r[LO_G_MSB:LO_G_LSB],
        low1_r[LO_B_MSB:LO_B_LSB]};
    wire logic [PIX_W-1:0] pix2_nxt = {hi2[HI_R_MSB:HI_R_LSB],
        hi2[HI_G_MSB:HI_G_LSB], low2_r[LO_G_MSB:LO_G_LSB],
        low2_r[LO_B_MSB:LO_B_LSB]};

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_lvl_r  <= 1'b0;
            have_low_r <= 1'b0;
            low1_r     <= '0;
            low2_r     <= '0;
        end else begin
            clk_lvl_r <= clk_lvl_nxt;
            if (first_edge) begin
                have_low_r <= 1'b1;
                low1_r     <= d_s[HALF_W-1:0];
                low2_r     <= d_s[PORT2_MSB:PORT2_LSB];
            end else if (second_edge) begin
                have_low_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pix1_r <= '0;
            pix2_r <= '0;
            de_r   <= 1'b0;
            hs_r   <= 1'b0;
            vs_r   <= 1'b0;
            stb_r  <= 1'b0;
        end else begin
            stb_r <= second_edge;
            if (second_edge) begin
                pix1_r <= pix1_nxt;
                pix2_r <= two_s ? pix2_nxt : '0;
                de_r   <= de_s;
                hs_r   <= hs_s;
                vs_r   <= vs_s;
            end
        end
    end

    wire logic active = pol_s ? de_r : !de_r;
    wire logic blank  = !active;
    wire logic de_hi_sel = de_r ~^ pol_s;
    wire logic [WORD_W-1:0] de_pat_a = de_hi_sel ? DE_HI_A : DE_LO_A;
    wire logic [WORD_W-1:0] de_pat_b = de_hi_sel ? DE_HI_B : DE_LO_B;
    // Raw legacy word per port: {spare, de, vs, hs, R, G, B}
    wire logic [PORT_LANES*WORD_W-1:0] raw1 = {1'b0, de_r, vs_r, hs_r,
                                                pix1_r};
    wire logic [PORT_LANES*WORD_W-1:0] raw2 = {1'b0, de_r, vs_r, hs_r,
                                                pix2_r};

    logic [WORD_W-1:0] words [UNITS];

    genvar gi;
    generate
        for (gi = 0; gi < UNITS; gi++) begin : g_lane
            localparam int PL = gi % PORT_LANES;
            localparam bit P2 = (gi >= PORT_LANES) && (gi < LANES);
            wire logic lvl = (gi == 0) ? hs_r : ((gi == 1) ? vs_r : 1'b0);
            // sync patterns on lanes 0 and 1
            wire logic [WORD_W-1:0] sa = lvl ? SYN_HI_A : SYN_LO_A;
            wire logic [WORD_W-1:0] sb = lvl ? SYN_HI_B : SYN_LO_B;
            wire logic [PORT_LANES*WORD_W-1:0] raw_p = P2 ? raw2 : raw1;
            wire logic [PIX_W-1:0] pix_p = P2 ? pix2_r : pix1_r;
            wire logic [WORD_W-1:0] raw_w = (gi >= LANES) ? CLK_LANE_WORD :
                raw_p[PL*WORD_W +: WORD_W];
            wire logic [DATA6_W-1:0] d6 = (gi >= LANES) ? '0 :
                pix_p[PL*DATA6_W +: DATA6_W];
            // display-active on the primary clock lane
            wire logic frc = (gi == SEC_CLK) || ((gi == PRI_CLK) &&
                !(code_s && blank));
            // upper lanes only in two-pixel mode
            wire logic en = (gi < PORT_LANES) || (gi == PRI_CLK) || two_s;
            lane_balancer u_lane (
                .ref_clk_i   (ref_clk_i),
                .arst_n_i    (arst_n_i),
                .strobe_i    (stb_r),
                .enable_i    (en),
                .force_raw_i (frc),
                .balanced_i  (code_s),
                .blank_i     (blank),
                .raw_i       (raw_w),
                .pat_a_i     ((gi == PRI_CLK) ? de_pat_a : sa),
                .pat_b_i     ((gi == PRI_CLK) ? de_pat_b : sb),
                .data_i      (d6),
                .word_o      (words[gi])
            );
            if (gi < LANES) begin : g_out
                assign link_lanes_o[gi*WORD_W +: WORD_W] = words[gi];
            end
        end
    endgenerate

    assign primary_link_clock_lane_o = words[PRI_CLK];
    assign second_link_clock_lane_o  = words[SEC_CLK];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lane_enable_o         <= '0;
            second_clock_enable_o <= 1'b0;
            word_valid_o          <= 1'b0;
        end else begin
            lane_enable_o         <= {{PORT_LANES{two_s}},
                                      {PORT_LANES{1'b1}}};
            second_clock_enable_o <= two_s;
            word_valid_o          <= stb_r;
        end
    end

    property p_upper_off;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !two_s ##1 !two_s |-> lane_enable_o[LANES-1:PORT_LANES] == '0 &&
            !second_clock_enable_o;
    endproperty
    a_upper_off: assert property (p_upper_off)
        else $error("upper lanes enabled in single-pixel mode");

    property p_low_half;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        first_edge |=> low1_r == $past(d_s[HALF_W-1:0]);
    endproperty
    a_low_half: assert property (p_low_half)
        else $error("low half not captured at first edge");

    property p_high_red;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        second_edge |=> pix1_r[PX_R_MSB:PX_R_LSB] ==
            $past(d_s[HI_R_MSB:HI_R_LSB]);
    endproperty
    a_high_red: assert property (p_high_red)
        else $error("red not taken from second edge");

    property p_low_blue;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        second_edge |=> pix1_r[LO_B_MSB:LO_B_LSB] ==
            $past(low1_r[LO_B_MSB:LO_B_LSB]);
    endproperty
    a_low_blue: assert property (p_low_blue)
        else $error("blue not taken from first edge");

    property p_port2_red;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        second_edge && two_s |=> pix2_r[PX_R_MSB:PX_R_LSB] ==
            $past(d_s[PORT2_MSB:PX_R_LSB]);
    endproperty
    a_port2_red: assert property (p_port2_red)
        else $error("second pixel red wrong");

    property p_valid_lag;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        second_edge |=> stb_r ##1 word_valid_o;
    endproperty
    a_valid_lag: assert property (p_valid_lag)
        else $error("word valid not two cycles after second edge");

    property p_diff_hold;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !style_s && (p_s == n_s) |-> !first_edge && !(clk_lvl_r &&
            !clk_lvl_nxt);
    endproperty
    a_diff_hold: assert property (p_diff_hold)
        else $error("edge seen without a clock crossing");

    property p_de_swap;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !pol_s && de_r |-> de_pat_a == DE_LO_A && de_pat_b == DE_LO_B;
    endproperty
    a_de_swap: assert property (p_de_swap)
        else $error("display-active patterns not swapped");

    c_two_pixel: cover property (@(posedge ref_clk_i) stb_r && two_s);
    c_coded_blank: cover property (@(posedge ref_clk_i)
        stb_r && code_s && blank);
    c_diff_clk: cover property (@(posedge ref_clk_i)
        second_edge && !style_s);
endmodule : pixel_mapper

// file: sim/pixel_host.sv
// Purpose: host model driving double-pumped half-pixels
// Assumes: pixel clock period 400 ns, phase unrelated to ref_clk
// Notes:   clock stands low and data is inverted between frames
`timescale 1ns/10ps
module pixel_host
    import pixel_mapper_pkg::*;
(
    // Host pins
    output logic            pclk_p_o,
    output logic            pclk_n_o,
    output logic [IN_W-1:0] bits_o,
    output logic            de_o,
    output logic            hs_o,
    output logic            vs_o
);
    initial begin
        pclk_p_o = 1'b0;
        pclk_n_o = 1'b1;
        bits_o   = '0;
        de_o     = 1'b0;
        hs_o     = 1'b0;
        vs_o     = 1'b0;
    end

    // pixel clock far below 65 MHz
    task automatic send(input logic [IN_W-1:0] lo,
                        input logic [IN_W-1:0] hi,
                        input logic de,
                        input logic hs,
                        input logic vs);
        // low halves while the clock is high
        bits_o   = lo;
        de_o     = de;
        hs_o     = hs;
        vs_o     = vs;
        pclk_p_o = 1'b1;
        pclk_n_o = 1'b0;
        #200;
        // high halves after the falling crossing
        bits_o   = hi;
        pclk_p_o = 1'b0;
        pclk_n_o = 1'b1;
        #200;
    endtask : send

    // Released bus must not look like held data
    task automatic release_bus();
        bits_o = ~bits_o;
    endtask : release_bus
endmodule : pixel_host

// file: sim/double_pumped_pixel_mapper_tb_top.sv
// Purpose: self-checking bench for the pixel mapper
// Assumes: straps change only while the host is idle
// Notes:   expected words come from a lane disparity model
`timescale 1ns/10ps
module double_pumped_pixel_mapper_tb_top
    import pixel_mapper_pkg::*;
;
    logic                    ref_clk_i = 1'b0;
    logic                    arst_n_i;
    logic                    two_pixel;
    logic                    coding_en;
    logic                    style_sel;
    logic                    de_pol;
    logic                    pclk_p;
    logic                    pclk_n;
    logic [IN_W-1:0]         bits;
    logic                    de;
    logic                    hs;
    logic                    vs;
    logic [LANES*WORD_W-1:0] lanes;
    logic [WORD_W-1:0]       pri_word;
    logic [WORD_W-1:0]       sec_word;
    logic [LANES-1:0]        lane_en;
    logic                    sec_en;
    logic                    valid;
    logic [77:0]             exp_q [$];
    int                      rd [9];
    int                      fails = 0;
    int                      total_checks = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    pixel_host host (
        .pclk_p_o (pclk_p),
        .pclk_n_o (pclk_n),
        .bits_o   (bits),
        .de_o     (de),
        .hs_o     (hs),
        .vs_o     (vs)
    );

    pixel_mapper DUT (
        .ref_clk_i                  (ref_clk_i),
        .arst_n_i                   (arst_n_i),
        .pixel_clk_p_i              (pclk_p),
        .pixel_clk_n_i              (pclk_n),
        .pixel_input_bits_i         (bits),
        .display_active_i           (de),
        .hsync_i                    (hs),
        .vsync_i                    (vs),
        .two_pixel_mode_i           (two_pixel),
        .disparity_coding_enable_i  (coding_en),
        .clock_input_style_select_i (style_sel),
        .data_enable_polarity_i     (de_pol),
        .link_lanes_o               (lanes),
        .primary_link_clock_lane_o  (pri_word),
        .second_link_clock_lane_o   (sec_word),
        .lane_enable_o              (lane_en),
        .second_clock_enable_o      (sec_en),
        .word_valid_o               (valid)
    );

    function automatic int disp(input logic [6:0] w);
        return 2 * $countones(w) - 7;
    endfunction : disp

    // smaller running disparity wins, tie to first
    function automatic logic [6:0] pick(input int k, input logic [6:0] a,
                                        input logic [6:0] b);
        int da;
        int db;
        da = rd[k] + disp(a);
        db = rd[k] + disp(b);
        pick = (db * db < da * da) ? b : a;
        rd[k] = rd[k] + disp(pick);
    endfunction : pick

    task automatic note(input logic [IN_W-1:0] lo, input logic [IN_W-1:0] hi,
                        input logic d_a, input logic h, input logic v);
        logic [PIX_W-1:0] p [2];
        logic [27:0]      raw;
        logic [5:0]       d;
        logic [6:0]       w;
        logic [6:0]       c1;
        logic [55:0]      ln;
        logic             act;
        logic             inv;
        // pixel is {high half, low half}
        p[0] = {hi[11:0], lo[11:0]};
        p[1] = two_pixel ? {hi[23:12], lo[23:12]} : '0;
        // polarity decides what counts as active
        act = de_pol ? d_a : ~d_a;
        ln = '0;
        c1 = CLK_LANE_WORD;
        if (!coding_en) rd = '{default: 0};
        for (int k = 0; k < 8; k++) begin
            raw = {1'b0, d_a, v, h, p[k/4]};
            d = p[k/4][6*(k%4)+:6];
            inv = (rd[k] > 0 && $countones(d) > 3) ||
                  (rd[k] < 0 && $countones(d) <= 3);
            if (k >= 4 && !two_pixel) w = WORD_ZERO;
            else if (!coding_en) w = raw[7*(k%4)+:7];
            else if (act) begin
                w = {inv, d ^ {6{inv}}};
                rd[k] = rd[k] + disp(w);
            end
            else if (k == 0) w = h ? pick(0, SYN_HI_A, SYN_HI_B)
                                   : pick(0, SYN_LO_A, SYN_LO_B);
            else if (k == 1) w = v ? pick(1, SYN_HI_A, SYN_HI_B)
                                   : pick(1, SYN_LO_A, SYN_LO_B);
            else w = pick(k, SYN_LO_A, SYN_LO_B);
            ln[7*k+:7] = w;
        end
        // blank under either polarity uses the low-level set
        if (coding_en && !act) c1 = pick(8, DE_LO_A, DE_LO_B);
        exp_q.push_back({ln, c1, two_pixel ? CLK_LANE_WORD : WORD_ZERO,
                         {4{two_pixel}}, 4'hf});
    endtask : note

    task automatic chk(input logic [77:0] got, input logic [77:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic results();
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end
        else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Output watcher takes the oldest note per new word
    always @(posedge ref_clk_i) begin
        logic [77:0] e;
        if (valid === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            chk(78'(lanes), 78'(e[77:22]));
            chk(78'(pri_word), 78'(e[21:15]));
            chk(78'({sec_word, lane_en, sec_en}),
                78'({e[14:0], e[7]}));
        end
    end

    initial begin
        #250000;
        fails++;
        results();
    end

    initial begin
        logic [IN_W-1:0] lo;
        logic [IN_W-1:0] hi;
        logic            d_a;
        logic            h;
        logic            v;
        arst_n_i  = 1'b0;
        two_pixel = 1'b0;
        coding_en = 1'b0;
        style_sel = 1'b0;
        de_pol    = 1'b0;
        rd = '{default: 0};
        void'($urandom(32'heba30daf));
        repeat (12) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        // both clock styles in every strap combination
        for (int m = 0; m < 16; m++) begin
            @(posedge ref_clk_i);
            two_pixel <= m[0];
            style_sel <= m[1];
            de_pol    <= m[2];
            coding_en <= m[3];
            repeat (6) @(posedge ref_clk_i);
            #3;
            for (int n = 0; n < 12; n++) begin
                lo  = IN_W'($urandom);
                hi  = IN_W'($urandom);
                d_a = ($urandom % 4) != 0;
                h   = 1'($urandom);
                v   = 1'($urandom);
                note(lo, hi, d_a, h, v);
                host.send(lo, hi, d_a, h, v);
            end
            host.release_bus();
            repeat (16) @(posedge ref_clk_i);
        end
        chk(78'(exp_q.size()), 78'(0));
        results();
    end
endmodule : double_pumped_pixel_mapper_tb_top
